// file: verilog/optical_tx_pkg.sv
// Constants and types shared by the transceiver control and status logic.
// Assumes a single management clock and an externally resolved two-wire bus.
`default_nettype none

package optical_tx_pkg;

    // ========================================================================
    // Two-wire slave addresses, in 7-bit form.
    localparam logic [6:0] ID_SPACE_ADDR   = 7'h50;
    localparam logic [6:0] DIAG_SPACE_ADDR = 7'h51;

    // ========================================================================
    // Diagnostic space layout.
    localparam logic [7:0] TEMP_OFFSET     = 8'h60;
    localparam logic [7:0] VCC_OFFSET      = 8'h62;
    localparam logic [7:0] BIAS_OFFSET     = 8'h64;
    localparam logic [7:0] TX_POWER_OFFSET = 8'h66;
    localparam logic [7:0] RX_POWER_OFFSET = 8'h68;
    localparam logic [7:0] STATUS_OFFSET   = 8'h6E;

    // ========================================================================
    // Fields of the status and control byte.
    localparam int PIN_OFF_BIT   = 7;
    localparam int SOFT_OFF_BIT  = 6;
    localparam int FAULT_BIT     = 2;
    localparam int LOS_BIT       = 1;
    localparam logic SOFT_OFF_RESET = 1'b0;

    // ========================================================================
    // Bit count of one byte on the link.
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Live monitor readings, each a big-endian 16-bit word.
    typedef struct packed {
        logic [15:0] temperature;
        logic [15:0] supply_voltage;
        logic [15:0] laser_bias;
        logic [15:0] tx_power;
        logic [15:0] rx_power;
    } monitor_type;

    typedef enum logic [3:0] {
        LINK_IDLE      = 4'b0000,
        LINK_ADDR      = 4'b0001,
        LINK_ADDR_ACK  = 4'b0010,
        LINK_WORD      = 4'b0011,
        LINK_WORD_ACK  = 4'b0100,
        LINK_WDATA     = 4'b0101,
        LINK_WDATA_ACK = 4'b0110,
        LINK_RDATA     = 4'b0111,
        LINK_RDATA_ACK = 4'b1000
    } link_state_type;

endpackage

`default_nettype wire

// file: verilog/optical_tx_control.sv
// Transmit control, fault latch, status byte and two-wire management slave.
// Assumes scl and sda levels are synchronous to mclk and sampled often enough
// to see every edge; the bench resolves the open-drain wires from the enables.
//
// Notes on behaviour
// (R1) Transmitter output is off while the transmit-off input is high.
// (R2) An undriven transmit-off input counts as high, keeping the laser off.
// (R3) Software transmit-off bit is writable at diagnostic byte 110 bit 6.
// (R4) Laser is off when software bit OR hardware input is asserted.
// (R5) Hardware transmit-off input state reads at byte 110 bit 7.
// (R6) A detected laser fault raises the fault output and disables the laser.
// (R7) Fault output is low in normal operation and high on a fault.
// (R8) Fault stays latched until transmit-off is toggled or power is cycled.
// (R9) Cycling transmit-off high then low resets the device after a fault.
// (R10) Laser-fault state reads at byte 110 bit 2.
// (R11) Identification space of 256 bytes answers at address 0xA0.
// (R12) Diagnostic space of 256 bytes answers at address 0xA2.
// (R13) Voltage, temperature, bias, transmit and receive power read live.
// (R14) Transmit-off and loss-of-signal flags are mirrored into diagnostic memory.
// (R15) Loss-of-signal state reads at byte 110 bit 1.
// (R16) Loss-of-signal output is high when the modulated input is lost.
// (R17) Standard start, address, acknowledge and stop sequencing as a slave.
`default_nettype none

module optical_tx_control (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    // Transmit-off pin, with its drive status from the pad
    input  wire logic                      tx_off_in,
    input  wire logic                      tx_off_driven,
    // Optics front end
    input  wire logic                      laser_fault_detect,
    input  wire logic                      signal_lost_flag,
    input  wire optical_tx_pkg::monitor_type readings,
    output var  logic                      laser_on,
    // Open-drain fault pin
    output var  logic                      tx_fault_out,
    output var  logic                      tx_fault_oe,
    // Loss-of-signal pin
    output var  logic                      receive_signal_lost,
    // Two-wire management link
    input  wire logic                      scl_in,
    input  wire logic                      sda_in,
    output var  logic                      sda_out,
    output var  logic                      sda_oe
);
    import optical_tx_pkg::*;

    // ========================================================================
    // Transmit control and fault latch
    logic           pin_off;
    logic           pin_off_prev;
    logic           soft_off;
    logic           fault;
    logic           pin_released;

    assign pin_off      = tx_off_driven ? tx_off_in : 1'b1; // (R2)
    assign pin_released = pin_off_prev & ~pin_off;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_off_prev <= 1'b1;
        end else begin
            pin_off_prev <= pin_off;
        end
    end

    // A new fault in the same cycle as the release wins, so none is lost.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fault <= 1'b0;
        end else if (laser_fault_detect) begin
            fault <= 1'b1; // (R6)
        end else if (pin_released) begin
            fault <= 1'b0; // (R8) (R9)
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            laser_on            <= 1'b0;
            tx_fault_oe         <= 1'b1;
            receive_signal_lost <= 1'b1;
        end else begin
            laser_on            <= ~(pin_off | soft_off | fault | laser_fault_detect); // (R1) (R4) (R6)
            tx_fault_oe         <= ~(fault | laser_fault_detect); // (R7)
            receive_signal_lost <= signal_lost_flag; // (R16)
        end
    end

    // The fault pin only ever pulls low; the host pull-up shows a fault.
    assign tx_fault_out = 1'b0;
    assign sda_out      = 1'b0;

    // ========================================================================
    // Memory spaces
    logic [7:0]     id_mem [0:255];
    logic [7:0]     diag_mem [0:255];
    logic [7:0]     status_byte;
    logic           space_diag;
    logic [7:0]     pointer;

    assign status_byte = {pin_off, soft_off, 3'b000, fault, signal_lost_flag, 1'b0}; // (R5) (R10) (R14) (R15)

    function automatic logic [7:0] read_byte(input logic diag, input logic [7:0] addr);
        logic [7:0] value;
        value = 8'h00;
        if (!diag) begin
            value = id_mem[addr]; // (R11)
        end else begin
            case (addr) // (R12) (R13)
                TEMP_OFFSET:            value = readings.temperature[15:8];
                TEMP_OFFSET + 8'h01:    value = readings.temperature[7:0];
                VCC_OFFSET:             value = readings.supply_voltage[15:8];
                VCC_OFFSET + 8'h01:     value = readings.supply_voltage[7:0];
                BIAS_OFFSET:            value = readings.laser_bias[15:8];
                BIAS_OFFSET + 8'h01:    value = readings.laser_bias[7:0];
                TX_POWER_OFFSET:        value = readings.tx_power[15:8];
                TX_POWER_OFFSET + 8'h01: value = readings.tx_power[7:0];
                RX_POWER_OFFSET:        value = readings.rx_power[15:8];
                RX_POWER_OFFSET + 8'h01: value = readings.rx_power[7:0];
                STATUS_OFFSET:          value = status_byte;
                default:                value = diag_mem[addr];
            endcase
        end
        return value;
    endfunction

    // ========================================================================
    // Two-wire slave
    logic           scl_d;
    logic           scl_p;
    logic           sda_d;
    logic           sda_p;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_seen;
    logic           stop_seen;
    link_state_type state;
    logic [3:0]     bit_count;
    logic [7:0]     shifter;
    logic [7:0]     next_byte;
    logic           write_strobe;
    logic [7:0]     write_data;

    assign scl_rise   = ~scl_p & scl_d;
    assign scl_fall   = scl_p & ~scl_d;
    assign start_seen = scl_d & scl_p & sda_p & ~sda_d; // (R17)
    assign stop_seen  = scl_d & scl_p & ~sda_p & sda_d; // (R17)
    assign next_byte  = read_byte(space_diag, pointer);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d <= 1'b1;
            scl_p <= 1'b1;
            sda_d <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_d <= scl_in;
            scl_p <= scl_d;
            sda_d <= sda_in;
            sda_p <= sda_d;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= LINK_IDLE;
            bit_count    <= 4'h0;
            shifter      <= 8'h00;
            sda_oe       <= 1'b0;
            space_diag   <= 1'b0;
            pointer      <= 8'h00;
            write_strobe <= 1'b0;
            write_data   <= 8'h00;
        end else begin
            write_strobe <= 1'b0;
            if (start_seen) begin
                state     <= LINK_ADDR; // (R17)
                bit_count <= 4'h0;
                sda_oe    <= 1'b0;
            end else if (stop_seen) begin
                state  <= LINK_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise && state != LINK_IDLE && state != LINK_ADDR_ACK && bit_count != BYTE_BITS) begin
                if (state != LINK_RDATA) begin
                    shifter <= {shifter[6:0], sda_d};
                end
                bit_count <= bit_count + 4'h1;
            end else if (scl_rise && state == LINK_RDATA_ACK && sda_d) begin
                state <= LINK_IDLE; // Master declined further data.
            end else if (scl_fall) begin
                case (state)
                    LINK_ADDR: begin
                        if (bit_count == BYTE_BITS) begin
                            if (shifter[7:1] == ID_SPACE_ADDR || shifter[7:1] == DIAG_SPACE_ADDR) begin
                                space_diag <= shifter[1];
                                sda_oe     <= 1'b1; // (R17)
                                state      <= LINK_ADDR_ACK;
                                bit_count  <= {3'b000, shifter[0]};
                            end else begin
                                state <= LINK_IDLE;
                            end
                        end
                    end
                    LINK_ADDR_ACK: begin
                        if (bit_count[0]) begin
                            shifter   <= {next_byte[6:0], 1'b0};
                            sda_oe    <= ~next_byte[7];
                            pointer   <= pointer + 8'h01;
                            state     <= LINK_RDATA;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= LINK_WORD;
                        end
                        bit_count <= 4'h0;
                    end
                    LINK_WORD: begin
                        if (bit_count == BYTE_BITS) begin
                            pointer <= shifter;
                            sda_oe  <= 1'b1;
                            state   <= LINK_WORD_ACK;
                        end
                    end
                    LINK_WDATA: begin
                        if (bit_count == BYTE_BITS) begin
                            write_strobe <= 1'b1;
                            write_data   <= shifter;
                            sda_oe       <= 1'b1;
                            state        <= LINK_WDATA_ACK;
                        end
                    end
                    LINK_WORD_ACK, LINK_WDATA_ACK: begin
                        if (state == LINK_WDATA_ACK) begin
                            pointer <= pointer + 8'h01;
                        end
                        sda_oe    <= 1'b0;
                        bit_count <= 4'h0;
                        state     <= LINK_WDATA;
                    end
                    LINK_RDATA: begin
                        if (bit_count == BYTE_BITS) begin
                            sda_oe <= 1'b0;
                            state  <= LINK_RDATA_ACK;
                        end else begin
                            sda_oe  <= ~shifter[7];
                            shifter <= {shifter[6:0], 1'b0};
                        end
                    end
                    LINK_RDATA_ACK: begin
                        shifter   <= {next_byte[6:0], 1'b0};
                        sda_oe    <= ~next_byte[7];
                        pointer   <= pointer + 8'h01;
                        bit_count <= 4'h0;
                        state     <= LINK_RDATA;
                    end
                    LINK_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state  <= LINK_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ========================================================================
    // Memory writes; live readings are read-only and only bit 6 of the status
    // byte takes a write. The arrays have no reset, so unwritten bytes are unknown.
    always_ff @(posedge mclk) begin
        if (write_strobe && !space_diag) begin
            id_mem[pointer] <= write_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (write_strobe && space_diag) begin
            diag_mem[pointer] <= write_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_off <= SOFT_OFF_RESET;
        end else if (write_strobe && space_diag && pointer == STATUS_OFFSET) begin
            soft_off <= write_data[SOFT_OFF_BIT]; // (R3)
        end
    end

endmodule

`default_nettype wire

// file: testbench/optical_tx_control_properties.sv
// Checker for the transmit control block, bound to its top module.
// Assumes link clock phases of at least four mclk cycles.
`default_nettype none
module optical_tx_control_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control pins
    input wire logic tx_off_in,
    input wire logic tx_off_driven,
    input wire logic laser_fault_detect,
    input wire logic signal_lost_flag,
    input wire logic laser_on,
    input wire logic tx_fault_out,
    input wire logic tx_fault_oe,
    input wire logic receive_signal_lost,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // An undriven pin reads high through its pull-up.
    wire logic pin_off = tx_off_in | ~tx_off_driven;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // ========================================================================
    // Pins
    a_pin_off_dark: assert property (pin_off |=> !laser_on)
        else $error("laser on after pin off");
    a_undriven_dark: assert property (!tx_off_driven |=> !laser_on)
        else $error("laser on with pin undriven");
    a_fault_raise: assert property (laser_fault_detect |=> !tx_fault_oe && !laser_on)
        else $error("fault not raised");
    a_fault_held: assert property (!tx_fault_oe && pin_off && $past(pin_off) && $past(pin_off, 2)
        |=> !tx_fault_oe)
        else $error("fault dropped without toggle");
    a_laser_needs: assert property (laser_on |-> tx_fault_oe && !$past(pin_off))
        else $error("laser on while off requested");
    a_los_follow: assert property ($past(reset_n) |-> receive_signal_lost == $past(signal_lost_flag))
        else $error("loss flag not followed");
    // ========================================================================
    // Open-drain outputs
    a_open_drain: assert property (tx_fault_out == 1'b0 && sda_out == 1'b0)
        else $error("open-drain data not low");
    a_sda_steady: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe))
        else $error("slave moved data while clock high");
    c_fault: cover property (laser_fault_detect ##1 !tx_fault_oe);
    c_ack: cover property ($rose(sda_oe));
    c_laser: cover property ($rose(laser_on));
endmodule
bind optical_tx_control optical_tx_control_properties i_props (
    .mclk(mclk), .reset_n(reset_n), .tx_off_in(tx_off_in), .tx_off_driven(tx_off_driven),
    .laser_fault_detect(laser_fault_detect), .signal_lost_flag(signal_lost_flag), .laser_on(laser_on),
    .tx_fault_out(tx_fault_out), .tx_fault_oe(tx_fault_oe), .receive_signal_lost(receive_signal_lost),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// file: testbench/optical_tx_host.sv
// Host board model: two-wire master with open-drain pull outputs.
// Assumes the bench resolves both wires with pull-ups.
`default_nettype none
module optical_tx_host (
    // Clock
    input  wire logic mclk,
    // Two-wire link
    input  wire logic sda_in,
    output var  logic scl_pull,
    output var  logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // ========================================================================
    // Six cycles a phase, so the slave's two-flop sampling sees every edge.
    task automatic hold();
        repeat (6) @(negedge mclk);
    endtask
    task automatic start_cond();
        sda_pull = 1'b0;
        hold();
        scl_pull = 1'b0;
        hold();
        sda_pull = 1'b1;
        hold();
        scl_pull = 1'b1;
        hold();
    endtask
    task automatic stop_cond();
        sda_pull = 1'b1;
        hold();
        scl_pull = 1'b0;
        hold();
        sda_pull = 1'b0;
        hold();
    endtask
    // Data only changes while the clock is held low.
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull = ~b;
        hold();
        scl_pull = 1'b0;
        hold();
        r = sda_in;
        scl_pull = 1'b1;
        hold();
    endtask
    task automatic xfer_byte(input logic [7:0] d, input logic ack_out, output logic [7:0] q, output logic ack_in);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
            q = {q[6:0], r};
        end
        xfer_bit(ack_out, ack_in);
    endtask
endmodule
`default_nettype wire

// file: testbench/optical_tx_control_tb_top.sv
// Testbench for the transmit control block with a host model on the link.
// Assumes pull-ups on both link wires.
`default_nettype none
module optical_tx_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import optical_tx_pkg::*;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        tx_off_in = 1'b1;
    logic        tx_off_driven = 1'b1;
    logic        laser_fault_detect = 1'b0;
    logic        signal_lost_flag = 1'b0;
    monitor_type readings = 80'h1234_5678_9ABC_DEF0_0F1E;
    logic        laser_on, tx_fault_out, tx_fault_oe, receive_signal_lost, sda_out, sda_oe, scl_pull, sda_pull;
    wire logic   scl_line = ~scl_pull;
    wire logic   sda_line = ~(sda_pull | sda_oe);
    int          miscompares = 0;
    int          n_compared = 0;
    always #20 mclk = ~mclk;
    optical_tx_control i_dut (.mclk(mclk), .reset_n(reset_n), .tx_off_in(tx_off_in),
        .tx_off_driven(tx_off_driven), .laser_fault_detect(laser_fault_detect),
        .signal_lost_flag(signal_lost_flag), .readings(readings), .laser_on(laser_on),
        .tx_fault_out(tx_fault_out), .tx_fault_oe(tx_fault_oe), .receive_signal_lost(receive_signal_lost),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
    optical_tx_host i_host (.mclk(mclk), .sda_in(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));
    // ========================================================================
    // Shared tasks
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        i_host.xfer_byte(d, 1'b1, q, a);
        check({7'h00, a}, 8'h00);
    endtask
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d);
        i_host.start_cond();
        put({dev, 1'b0});
        put(off);
        put(d);
        i_host.stop_cond();
    endtask
    // Random read: pointer write, repeated start, one byte closed by a NACK.
    task automatic expect_read(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] exp);
        logic [7:0] q;
        logic       a;
        i_host.start_cond();
        put({dev, 1'b0});
        put(off);
        i_host.start_cond();
        put({dev, 1'b1});
        i_host.xfer_byte(8'hFF, 1'b1, q, a);
        i_host.stop_cond();
        check(q, exp);
    endtask
    // ========================================================================
    // Scenarios
    task automatic t_pins();
        tx_off_in = 1'b0;
        step(2);
        check({7'h00, laser_on}, 8'h01);
        tx_off_in = 1'b1;
        step(2);
        check({7'h00, laser_on}, 8'h00);
        expect_read(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'h80);
        tx_off_in = 1'b0;
        tx_off_driven = 1'b0;
        step(2);
        check({7'h00, laser_on}, 8'h00);
        expect_read(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'h80);
        tx_off_driven = 1'b1;
        step(2);
    endtask
    task automatic t_soft();
        reg_write(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'hFF);
        expect_read(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'h40);
        check({7'h00, laser_on}, 8'h00);
        reg_write(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'h00);
        step(2);
        check({7'h00, laser_on}, 8'h01);
    endtask
    task automatic t_fault();
        laser_fault_detect = 1'b1;
        step(1);
        laser_fault_detect = 1'b0;
        step(1);
        check({6'h00, laser_on, tx_fault_oe}, 8'h00);
        step(8);
        check({6'h00, laser_on, tx_fault_oe}, 8'h00);
        expect_read(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'h04);
        tx_off_in = 1'b1;
        step(3);
        check({6'h00, laser_on, tx_fault_oe}, 8'h00);
        tx_off_in = 1'b0;
        step(4);
        check({6'h00, laser_on, tx_fault_oe}, 8'h03);
    endtask
    task automatic t_los();
        signal_lost_flag = 1'b1;
        step(2);
        check({7'h00, receive_signal_lost}, 8'h01);
        expect_read(DIAG_SPACE_ADDR, STATUS_OFFSET, 8'h02);
        signal_lost_flag = 1'b0;
        step(2);
        check({7'h00, receive_signal_lost}, 8'h00);
    endtask
    task automatic t_spaces();
        logic [7:0] q;
        logic       a;
        reg_write(ID_SPACE_ADDR, 8'hFF, 8'hA5);
        reg_write(ID_SPACE_ADDR, 8'h00, 8'h5A);
        reg_write(DIAG_SPACE_ADDR, 8'h00, 8'hC3);
        expect_read(ID_SPACE_ADDR, 8'hFF, 8'hA5);
        expect_read(ID_SPACE_ADDR, 8'h00, 8'h5A);
        expect_read(DIAG_SPACE_ADDR, 8'h00, 8'hC3);
        for (int i = 0; i < 10; i++) begin
            expect_read(DIAG_SPACE_ADDR, 8'(TEMP_OFFSET + i), readings[79 - 8 * i -: 8]);
        end
        i_host.start_cond();
        i_host.xfer_byte(8'hA4, 1'b1, q, a);
        i_host.stop_cond();
        check({7'h00, a}, 8'h01);
    endtask
    // Burst write, burst read acknowledged by the host, then a current-address read.
    task automatic t_burst();
        logic [7:0] q;
        logic       a;
        i_host.start_cond();
        put({ID_SPACE_ADDR, 1'b0});
        put(8'h10);
        put(8'h11);
        put(8'h22);
        put(8'h33);
        i_host.stop_cond();
        i_host.start_cond();
        put({ID_SPACE_ADDR, 1'b0});
        put(8'h10);
        i_host.start_cond();
        put({ID_SPACE_ADDR, 1'b1});
        i_host.xfer_byte(8'hFF, 1'b0, q, a);
        check(q, 8'h11);
        i_host.xfer_byte(8'hFF, 1'b1, q, a);
        check(q, 8'h22);
        i_host.stop_cond();
        i_host.start_cond();
        put({ID_SPACE_ADDR, 1'b1});
        i_host.xfer_byte(8'hFF, 1'b1, q, a);
        i_host.stop_cond();
        check(q, 8'h33);
    endtask
    // A reset in mid-run stands for a power cycle and clears a latched fault.
    task automatic t_reset();
        laser_fault_detect = 1'b1;
        step(1);
        laser_fault_detect = 1'b0;
        reset_n = 1'b0;
        step(2);
        check({6'h00, laser_on, tx_fault_oe}, 8'h01);
        check({6'h00, tx_fault_out, sda_out}, 8'h00);
        reset_n = 1'b1;
        step(3);
        check({6'h00, laser_on, tx_fault_oe}, 8'h03);
    endtask
    task automatic give_verdict();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(4);
        reset_n = 1'b1;
        step(3);
        t_pins();
        t_soft();
        t_fault();
        t_los();
        t_spaces();
        t_burst();
        t_reset();
        give_verdict();
    end
    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
